// ===== drt_pkg.sv
// Constants, field layouts and bus carriers for the debug discovery table register bank.
// Assumes a single debug bus clock and a 32-bit register bus with aligned word accesses.
// Operation
// [RULE1] Up to 512 component entries sit back to back from offset zero.
// [RULE2] The entry after the last component reads presence code 0b00, ending the list.
// [RULE3] The slot at offset 0x7fc only holds code 0b00 or 0b11 and is final; only format zero reads 0b10 there as 0b00, and 0b01 passes.
// [RULE4] Format zero gives 32-bit entries; format one gives 64-bit entries at eight-byte stride.
// [RULE5] Upper bits from bit 12 hold the 4KB block offset of the component.
// [RULE6] The block offset is two's complement and may point below the table.
// [RULE7] A present entry never carries a zero block offset.
// [RULE8] A multi-block component's offset selects its identification block.
// [RULE9] Domain field 0x00 to 0x1f is valid only with bit 2 set, else zero.
// [RULE10] Codes: 00 absent final, 01 reserved, 10 absent not final, 11 present.
// [RULE11] Identification size field bits 7:4 reads 0x0: one 4KB block.
// [RULE12] Feature bit 5 tells whether system reset request registers exist.
// [RULE13] Feature bit 4 tells whether debug reset request registers exist.
// [RULE14] Feature low nibble reads 0000 without power requests, 0001 with version 0.
// [RULE15] One power control register per system domain, up to 32 domains.
// [RULE16] System power requests are ignored while all debug is disabled.
// [RULE17] Bit 1 is the writable power request; bits 31:2 read zero.
// [RULE18] Request bit one asks for power; it is reserved where no mechanism exists.
// [RULE19] Bit 0 is read-only and shows the domain's request mechanism is present.
// [RULE20] Writes to read-only registers are ignored without side effects.
package drt_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MAX_ENTRIES = 512;
  localparam int unsigned MAX_DOMAINS = 32;
  localparam logic [11:0] ENTRY_BASE_OFS = 12'h000;
  localparam logic [11:0] ENTRY_LAST_OFS = 12'h7fc;
  localparam logic [11:0] PWR_CTRL_BASE_OFS = 12'hb00;
  localparam logic [11:0] PWR_CTRL_LAST_OFS = 12'hb7c;
  localparam logic [11:0] POWER_RESET_FEATURES_OFS = 12'hc00;
  localparam logic [11:0] PERIPHERAL_IDENT_4_OFS = 12'hfd0;
  localparam logic [11:0] PERIPHERAL_IDENT_5_OFS = 12'hfd4;
  localparam logic [11:0] PERIPHERAL_IDENT_6_OFS = 12'hfd8;
  localparam logic [11:0] PERIPHERAL_IDENT_7_OFS = 12'hfdc;
  localparam logic [11:0] PERIPHERAL_IDENT_0_OFS = 12'hfe0;
  localparam logic [11:0] PERIPHERAL_IDENT_1_OFS = 12'hfe4;
  localparam logic [11:0] PERIPHERAL_IDENT_2_OFS = 12'hfe8;
  localparam logic [11:0] PERIPHERAL_IDENT_3_OFS = 12'hfec;
  localparam int unsigned PRESENT_LSB = 0;
  localparam int unsigned DOMAIN_VALID_BIT = 2;
  localparam int unsigned DOMAIN_LSB = 4;
  localparam int unsigned BLOCK_OFS_LSB = 12;
  localparam logic [1:0] PRES_ABSENT_FINAL = 2'h0;
  localparam logic [1:0] PRES_RESERVED = 2'h1;
  localparam logic [1:0] PRES_ABSENT_MORE = 2'h2;
  localparam logic [1:0] PRES_PRESENT = 2'h3;
  localparam int unsigned SYS_RESET_REQ_BIT = 5;
  localparam int unsigned DBG_RESET_REQ_BIT = 4;
  localparam logic [3:0] PWR_REQ_VER_NONE = 4'h0;
  localparam logic [3:0] PWR_REQ_VER_0 = 4'h1;
  localparam int unsigned SIZE_LSB = 4;
  localparam logic [3:0] SIZE_ONE_BLOCK = 4'h0;
  localparam int unsigned MECH_PRESENT_BIT = 0;
  localparam int unsigned POWER_REQUEST_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [2:0] prot;
  } drt_addr_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } drt_wdata_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] resp;
  } drt_rdata_type;
endpackage : drt_pkg

// ===== drt_regs.sv
// Debug discovery table register bank behind an AXI4-Lite slave.
// Assumes a synchronous active-low reset on aclk; entry contents come from the entry_table port.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module drt_regs
  import drt_pkg::*;
#(
  parameter int unsigned NUM_DOMAINS = MAX_DOMAINS,
  parameter logic [31:0] DOMAIN_MECH_MASK = 32'hffff_ffff,
  parameter bit ENTRY_FORMAT_64 = 1'b0,
  parameter bit SYS_RESET_REQ_IMPL = 1'b0,
  parameter bit DBG_RESET_REQ_IMPL = 1'b0,
  parameter logic [7:0] IDENT_0 = 8'h00,
  parameter logic [7:0] IDENT_1 = 8'h00,
  parameter logic [7:0] IDENT_2 = 8'h00,
  parameter logic [7:0] IDENT_3 = 8'h00,
  parameter logic [3:0] IDENT_4_LOW = 4'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire drt_addr_type aw,
  input wire logic wvalid,
  output logic wready,
  input wire drt_wdata_type w,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire drt_addr_type ar,
  output logic rvalid,
  input wire logic rready,
  output drt_rdata_type r,
  input wire logic [MAX_ENTRIES*DATA_W-1:0] entry_table,
  input wire logic debug_all_disabled,
  output logic [MAX_DOMAINS-1:0] power_request
);

  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic aw_have_q, aw_have_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic w_have_q, w_have_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  drt_rdata_type r_q, r_d;
  logic [MAX_DOMAINS-1:0] preq_q, preq_d;
  logic [MAX_DOMAINS-1:0] mech;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;
  logic [9:0] entry_idx;
  logic [DATA_W-1:0] entry_word;
  logic [4:0] dom_idx;
  logic wr_fire;

  assign awready = ~aw_have_q & ~bvalid_q;
  assign wready = ~w_have_q & ~bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign r = r_q;
  assign power_request = preq_q;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;

  // Domains beyond the configured count have no request mechanism.
  always_comb begin
    mech = '0;
    for (int i = 0; i < MAX_DOMAINS; i++) begin
      if (i < NUM_DOMAINS) begin
        mech[i] = DOMAIN_MECH_MASK[i]; // [RULE15]
      end
    end
  end

  // Entry words are read out of the table image with the list end, zero offset and domain field rules applied; 64-bit format uses two words each.
  assign entry_idx = ar.addr[11:2]; // [RULE1] [RULE4]
  always_comb begin
    entry_word = entry_table[entry_idx[8:0]*DATA_W +: DATA_W]; // [RULE5] [RULE6] [RULE8]
    if (entry_word[1:0] == PRES_ABSENT_FINAL) begin
      entry_word = ZERO_WORD; // [RULE2] [RULE10]
    end else if (entry_word[1:0] == PRES_PRESENT && entry_word[31:12] == 20'h00000) begin
      entry_word = ZERO_WORD; // [RULE7]
    end else if (!entry_word[DOMAIN_VALID_BIT]) begin
      entry_word[DOMAIN_LSB +: 5] = 5'h00; // [RULE9]
    end
    if (!ENTRY_FORMAT_64 && entry_idx[8:0] == ENTRY_LAST_OFS[10:2] && entry_word[1:0] == PRES_ABSENT_MORE) begin
      entry_word = ZERO_WORD; // [RULE3]
    end
  end

  assign dom_idx = ar.addr[6:2];

  always_comb begin
    rd_word = ZERO_WORD;
    rd_hit = 1'b1;
    if (ar.addr[11] == 1'b0) begin
      rd_word = entry_word;
    end else if (ar.addr >= PWR_CTRL_BASE_OFS && ar.addr <= PWR_CTRL_LAST_OFS) begin
      rd_word[MECH_PRESENT_BIT] = mech[dom_idx]; // [RULE19]
      rd_word[POWER_REQUEST_BIT] = preq_q[dom_idx]; // [RULE17]
    end else begin
      unique case (ar.addr)
        POWER_RESET_FEATURES_OFS: begin
          rd_word[SYS_RESET_REQ_BIT] = SYS_RESET_REQ_IMPL; // [RULE12]
          rd_word[DBG_RESET_REQ_BIT] = DBG_RESET_REQ_IMPL; // [RULE13]
          rd_word[3:0] = (|mech) ? PWR_REQ_VER_0 : PWR_REQ_VER_NONE; // [RULE14]
        end
        PERIPHERAL_IDENT_4_OFS: begin
          rd_word[7:0] = {SIZE_ONE_BLOCK, IDENT_4_LOW}; // [RULE11]
        end
        PERIPHERAL_IDENT_5_OFS, PERIPHERAL_IDENT_6_OFS, PERIPHERAL_IDENT_7_OFS: begin
          rd_word = ZERO_WORD;
        end
        PERIPHERAL_IDENT_0_OFS: begin
          rd_word[7:0] = IDENT_0;
        end
        PERIPHERAL_IDENT_1_OFS: begin
          rd_word[7:0] = IDENT_1;
        end
        PERIPHERAL_IDENT_2_OFS: begin
          rd_word[7:0] = IDENT_2;
        end
        PERIPHERAL_IDENT_3_OFS: begin
          rd_word[7:0] = IDENT_3;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end

  // Write channel capture, power request update and write response.
  always_comb begin
    aw_addr_d = aw_addr_q;
    aw_have_d = aw_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    preq_d = preq_q;
    if (awvalid && awready) begin
      aw_addr_d = aw.addr;
      aw_have_d = 1'b1;
    end
    if (wvalid && wready) begin
      w_data_d = w.data;
      w_strb_d = w.strb;
      w_have_d = 1'b1;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY; // [RULE20]
      if (aw_addr_q >= PWR_CTRL_BASE_OFS && aw_addr_q <= PWR_CTRL_LAST_OFS) begin
        if (w_strb_q[0] && mech[aw_addr_q[6:2]] && !debug_all_disabled) begin // [RULE16] [RULE18]
          preq_d[aw_addr_q[6:2]] = w_data_q[POWER_REQUEST_BIT]; // [RULE17]
        end
      end else if (aw_addr_q[11] && aw_addr_q != POWER_RESET_FEATURES_OFS && aw_addr_q < PERIPHERAL_IDENT_4_OFS) begin
        bresp_d = RESP_SLVERR;
      end
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    r_d = r_q;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      r_d.data = rd_hit ? rd_word : ZERO_WORD;
      r_d.resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      aw_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      r_q <= '0;
      preq_q <= '0;
    end else begin
      aw_addr_q <= aw_addr_d;
      aw_have_q <= aw_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      r_q <= r_d;
      preq_q <= preq_d;
    end
  end

  // Checks on the register bank behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ignore_disabled_a: assert property (wr_fire && debug_all_disabled |=> preq_q == $past(preq_q)) // [RULE16]
    else $error("Power request changed while debug disabled.");
  no_mech_zero_a: assert property ((preq_q & ~mech) == '0) // [RULE18]
    else $error("Request set on domain without mechanism.");
  ident_size_a: assert property (arvalid && arready && ar.addr == PERIPHERAL_IDENT_4_OFS
    |=> r_q.data[7:4] == SIZE_ONE_BLOCK && r_q.data[31:8] == '0) // [RULE11]
    else $error("Identification size field wrong.");
  features_a: assert property (arvalid && arready && ar.addr == POWER_RESET_FEATURES_OFS
    |=> r_q.data[5] == SYS_RESET_REQ_IMPL && r_q.data[4] == DBG_RESET_REQ_IMPL && r_q.data[31:6] == '0) // [RULE12]
    else $error("Feature reset bits wrong.");
  feature_ver_a: assert property (arvalid && arready && ar.addr == POWER_RESET_FEATURES_OFS
    |=> r_q.data[3:0] == ((|mech) ? PWR_REQ_VER_0 : PWR_REQ_VER_NONE)) // [RULE14]
    else $error("Feature version wrong.");
  pwr_read_a: assert property (arvalid && arready && ar.addr >= PWR_CTRL_BASE_OFS && ar.addr <= PWR_CTRL_LAST_OFS
    |=> r_q.data[31:2] == '0 && r_q.data[0] == mech[$past(dom_idx)]) // [RULE17]
    else $error("Power control read wrong.");
  entry_end_a: assert property (arvalid && arready && ar.addr[11] == 1'b0 && entry_word[1:0] == PRES_ABSENT_FINAL
    |=> r_q.data == ZERO_WORD) // [RULE2]
    else $error("Final entry not all zero.");
  entry_ofs_a: assert property (rvalid_q && $rose(rvalid_q) && $past(ar.addr[11]) == 1'b0 && r_q.data[1:0] != 2'h0
    |-> r_q.data[31:12] != 20'h00000) // [RULE7]
    else $error("Present entry has zero offset.");
  domain_zero_a: assert property (arvalid && arready && ar.addr[11] == 1'b0 && !entry_word[DOMAIN_VALID_BIT]
    |=> r_q.data[8:4] == 5'h00) // [RULE9]
    else $error("Domain field not zero.");
  ro_write_a: assert property (wr_fire && !(aw_addr_q >= PWR_CTRL_BASE_OFS && aw_addr_q <= PWR_CTRL_LAST_OFS)
    |=> preq_q == $past(preq_q)) // [RULE20]
    else $error("Read-only write had side effect.");
  resp_done_a: assert property (wr_fire |=> bvalid_q [*1] ##0 !awready)
    else $error("Write response missing.");
  last_slot_a: assert property (arvalid && arready && ar.addr == ENTRY_LAST_OFS && !ENTRY_FORMAT_64
    |=> r_q.data[1:0] != PRES_ABSENT_MORE) // [RULE3]
    else $error("Last slot reads as not final.");
  entry_okay_a: assert property (arvalid && arready && ar.addr[11] == 1'b0
    |=> r_q.resp == RESP_OKAY) // [RULE1]
    else $error("Entry read not answered okay.");
  entry_nonzero_a: assert property (arvalid && arready && ar.addr[11] == 1'b0 && entry_word[1:0] != PRES_ABSENT_FINAL
    |-> entry_word[31:12] != 20'h00000) // [RULE7]
    else $error("Entry with zero offset passed through.");
  domain_field_a: assert property (entry_word[1:0] == PRES_PRESENT && !entry_word[DOMAIN_VALID_BIT]
    |-> entry_word[8:4] == 5'h00) // [RULE9]
    else $error("Domain field shown without valid flag.");
  bresp_legal_a: assert property (bvalid_q |-> bresp_q == RESP_OKAY || bresp_q == RESP_SLVERR) // [RULE20]
    else $error("Illegal write response.");
  bvalid_hold_a: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
    else $error("Write response dropped before accepted.");
  rvalid_hold_a: assert property (rvalid_q && !rready |=> rvalid_q && $stable(r_q))
    else $error("Read data dropped before accepted.");
  mech_bounds_a: assert property (wr_fire && !mech[aw_addr_q[6:2]] |=> preq_q == $past(preq_q)) // [RULE15]
    else $error("Request taken for domain without mechanism.");

  read_entry_c: cover property (arvalid && arready && ar.addr[11] == 1'b0);
  pwr_set_c: cover property (wr_fire && !debug_all_disabled && aw_addr_q[11:8] == 4'hb);
  pwr_blocked_c: cover property (wr_fire && debug_all_disabled && aw_addr_q[11:8] == 4'hb);
  bad_read_c: cover property (rvalid_q && r_q.resp == RESP_SLVERR);
  pwr_clear_c: cover property (wr_fire && !debug_all_disabled && aw_addr_q[11:8] == 4'hb && !w_data_q[1]);

endmodule : drt_regs

// ===== drt_master.sv
// Register bus master that stands in for the debugger behind the access port.
// Assumes tb_top holds errors and test_done, used when a bounded wait runs out.
`timescale 1ns/10ps
module drt_master
  import drt_pkg::*;
(
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output drt_addr_type aw,
  output logic wvalid,
  input wire logic wready,
  output drt_wdata_type w,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output drt_addr_type ar,
  input wire logic rvalid,
  output logic rready,
  input wire drt_rdata_type r
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    aw = '0;
    w = '0;
    ar = '0;
  end

  // A payload that was taken is inverted each cycle, so nothing relies on a stale value.
  task automatic hung();
    $display("MISMATCH bus answer expected 1 seen 0");
    tb_top.errors++;
    tb_top.test_done();
  endtask : hung

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw <= '{addr: a, prot: 3'h0};
    w <= '{data: d, strb: s};
    do begin
      @(posedge aclk);
      n++;
      if (!awvalid || awready) begin
        awvalid <= 1'b0;
        aw <= ~aw;
      end
      if (!wvalid || wready) begin
        wvalid <= 1'b0;
        w <= ~w;
      end
    end while (bvalid !== 1'b1 && n < 50);
    rs = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) hung();
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar <= '{addr: a, prot: 3'h0};
    do begin
      @(posedge aclk);
      n++;
      if (!arvalid || arready) begin
        arvalid <= 1'b0;
        ar <= ~ar;
      end
    end while (rvalid !== 1'b1 && n < 50);
    d = r.data;
    rs = r.resp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) hung();
  endtask : rd
endmodule : drt_master

// ===== tb_top.sv
// Self-checking bench for the discovery table register bank.
// Assumes drt_master speaks the register bus and the table image stays static.
`timescale 1ns/10ps
module tb_top
  import drt_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp;
  drt_addr_type aw, ar;
  drt_wdata_type w;
  drt_rdata_type r;
  logic [MAX_ENTRIES*DATA_W-1:0] entry_table;
  logic debug_all_disabled;
  logic [MAX_DOMAINS-1:0] power_request;
  int errors;
  int checks_done;

  // Ident value 8'h5a is arbitrary.
  drt_regs #(.DOMAIN_MECH_MASK(32'h0000_000f), .SYS_RESET_REQ_IMPL(1'b1), .IDENT_0(8'h5a), .IDENT_4_LOW(4'h3)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .aw(aw), .wvalid(wvalid),
    .wready(wready), .w(w), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .ar(ar), .rvalid(rvalid), .rready(rready), .r(r), .entry_table(entry_table),
    .debug_all_disabled(debug_all_disabled), .power_request(power_request));

  drt_master bus_u (.aclk(aclk), .awvalid(awvalid), .awready(awready), .aw(aw), .wvalid(wvalid),
    .wready(wready), .w(w), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .ar(ar), .rvalid(rvalid), .rready(rready), .r(r));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] ers);
    logic [31:0] d;
    logic [1:0] rs;
    bus_u.rd(a, d, rs);
    chk("read data", d, exp);
    chk("read response", {30'h0, rs}, {30'h0, ers});
  endtask : rdchk

  task automatic wrchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] ers);
    logic [1:0] rs;
    bus_u.wr(a, d, 4'hf, rs);
    chk("write response", {30'h0, rs}, {30'h0, ers});
  endtask : wrchk

  task automatic pwrchk(input logic [31:0] exp);
    @(negedge aclk);
    chk("power requests", power_request, exp);
  endtask : pwrchk

  task automatic t_entries();
    rdchk(12'h000, 32'h0000_1057, RESP_OKAY);
    rdchk(12'h004, 32'hffff_f003, RESP_OKAY);
    rdchk(12'h00c, ZERO_WORD, RESP_OKAY);
    rdchk(12'h010, ZERO_WORD, RESP_OKAY);
    rdchk(12'h014, 32'h0000_3001, RESP_OKAY);
    rdchk(ENTRY_LAST_OFS, ZERO_WORD, RESP_OKAY);
    $display("test entries done");
  endtask : t_entries

  task automatic t_ident();
    rdchk(POWER_RESET_FEATURES_OFS, 32'h0000_0021, RESP_OKAY);
    rdchk(PERIPHERAL_IDENT_4_OFS, 32'h0000_0003, RESP_OKAY);
    rdchk(PERIPHERAL_IDENT_5_OFS, ZERO_WORD, RESP_OKAY);
    rdchk(PERIPHERAL_IDENT_0_OFS, 32'h0000_005a, RESP_OKAY);
    $display("test ident done");
  endtask : t_ident

  task automatic t_readonly();
    wrchk(12'h000, ZERO_WORD, RESP_OKAY);
    rdchk(12'h000, 32'h0000_1057, RESP_OKAY);
    wrchk(POWER_RESET_FEATURES_OFS, 32'hffff_ffff, RESP_OKAY);
    rdchk(POWER_RESET_FEATURES_OFS, 32'h0000_0021, RESP_OKAY);
    rdchk(12'h800, ZERO_WORD, RESP_SLVERR);
    wrchk(12'hb80, 32'h0000_0002, RESP_SLVERR);
    pwrchk(32'h0000_0000);
    $display("test read only done");
  endtask : t_readonly

  task automatic t_power();
    wrchk(12'hb04, 32'h0000_0002, RESP_OKAY);
    pwrchk(32'h0000_0002);
    rdchk(12'hb04, 32'h0000_0003, RESP_OKAY);
    wrchk(12'hb0c, 32'hffff_ffff, RESP_OKAY);
    rdchk(12'hb0c, 32'h0000_0003, RESP_OKAY);
    wrchk(12'hb10, 32'h0000_0003, RESP_OKAY);
    rdchk(12'hb10, ZERO_WORD, RESP_OKAY);
    pwrchk(32'h0000_000a);
    @(posedge aclk);
    debug_all_disabled <= 1'b1;
    wrchk(12'hb08, 32'h0000_0002, RESP_OKAY);
    pwrchk(32'h0000_000a);
    @(posedge aclk);
    debug_all_disabled <= 1'b0;
    wrchk(12'hb04, ZERO_WORD, RESP_OKAY);
    pwrchk(32'h0000_0008);
    $display("test power done");
  endtask : t_power

  task automatic t_rereset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    pwrchk(32'h0000_0000);
    rdchk(12'hb0c, 32'h0000_0001, RESP_OKAY);
    $display("test second reset done");
  endtask : t_rereset

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    errors = 0;
    checks_done = 0;
    aresetn = 1'b0;
    debug_all_disabled = 1'b0;
    entry_table = '0;
    entry_table[0+:32] = 32'h0000_1057;
    entry_table[32+:32] = 32'hffff_f053;
    entry_table[64+:32] = 32'h0000_2002;
    entry_table[96+:32] = 32'h1234_5670;
    entry_table[128+:32] = 32'h0000_0003;
    entry_table[160+:32] = 32'h0000_3001;
    entry_table[511*32+:32] = 32'h0000_5002;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_entries();
    t_ident();
    t_readonly();
    t_power();
    t_rereset();
    test_done();
  end
endmodule : tb_top
